// *** hw/ppih_regs.svh ***
`ifndef PPIH_REGS_SVH
`define PPIH_REGS_SVH

// Host data bus width
`define PPIH_DW          8
// Select codes on {port_select_hi, port_select_lo}
`define PPIH_SEL_FIRST   2'h0
`define PPIH_SEL_SECOND  2'h1
`define PPIH_SEL_THIRD   2'h2
`define PPIH_SEL_CTRL    2'h3

// Bus timing in ns, clock period in ns
`define PPIH_CLK_NS      4
`define PPIH_T_SETUP_NS  50
`define PPIH_T_STROBE_NS 400
`define PPIH_T_HOLD_NS   40
`define PPIH_T_RECOV_NS  1000
`define PPIH_T_RESET_NS  1000

// Least times, rounded up to whole cycles
`define PPIH_CYC(ns) (((ns) + `PPIH_CLK_NS - 1) / `PPIH_CLK_NS)
`define PPIH_SETUP_CYC  `PPIH_CYC(`PPIH_T_SETUP_NS)
`define PPIH_STROBE_CYC `PPIH_CYC(`PPIH_T_STROBE_NS)
`define PPIH_HOLD_CYC   `PPIH_CYC(`PPIH_T_HOLD_NS)
`define PPIH_RECOV_CYC  `PPIH_CYC(`PPIH_T_RECOV_NS)
`define PPIH_RESET_CYC  `PPIH_CYC(`PPIH_T_RESET_NS)
`define PPIH_CNT_W      8

`endif

// *** hw/ppih_pkg.sv ***
package ppih_pkg;
  typedef enum logic [2:0] {
    PPIH_RST,
    PPIH_IDLE,
    PPIH_SETUP,
    PPIH_STROBE,
    PPIH_HOLD,
    PPIH_RECOV
  } ppih_state_t;
endpackage

// *** hw/ppih_sync.sv ***
`timescale 1ns/1ps
module ppih_sync #(
  parameter int W = 8
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } ppih_sync_t;

  ppih_sync_t s;
  ppih_sync_t next_s;

  // A new value counts only once the second and third stages agree
  always_comb begin
    next_s    = s;
    next_s.s1 = din;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
    if (s.s2 == s.s3) begin
      next_s.q = s.s3;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.q;
endmodule

// *** hw/ppih_host.sv ***
`timescale 1ns/1ps
`include "ppih_regs.svh"

module ppih_host
  import ppih_pkg::*;
(
  input  wire logic               clk,
  input  wire logic               rst,
  input  wire logic               cmdValid,
  output logic                    cmdReady,
  input  wire logic               cmdWrite,
  input  wire logic [1:0]         cmdSel,
  input  wire logic [`PPIH_DW-1:0] cmdData,
  input  wire logic               devResetReq,
  output logic                    rspValid,
  output logic [`PPIH_DW-1:0]     rspData,
  output logic                    cmdIllegal,
  output logic                    busy,
  output logic                    deviceReset,
  output logic                    deviceSelect_n,
  output logic                    readStrobe_n,
  output logic                    writeStrobe_n,
  output logic                    portSelectLo,
  output logic                    portSelectHi,
  input  wire logic [`PPIH_DW-1:0] hostDataIn,
  output logic [`PPIH_DW-1:0]     hostDataOut,
  output logic                    hostDataOe
);
  typedef struct packed {
    ppih_state_t             state;
    logic [`PPIH_CNT_W-1:0]  cnt;
    logic [1:0]              sel;
    logic                    write;
    logic [`PPIH_DW-1:0]     dataOut;
    logic                    oe;
    logic                    csN;
    logic                    rdN;
    logic                    wrN;
    logic                    resetOut;
    logic                    rspValid;
    logic [`PPIH_DW-1:0]     rspData;
    logic                    illegal;
  } ppih_host_t;

  localparam ppih_host_t RESET_VAL = '{
    state:    PPIH_RST,
    cnt:      `PPIH_CNT_W'(`PPIH_RESET_CYC - 1),
    sel:      `PPIH_SEL_FIRST,
    write:    1'b0,
    dataOut:  '0,
    oe:       1'b0,
    csN:      1'b1,
    rdN:      1'b1,
    wrN:      1'b1,
    resetOut: 1'b1,
    rspValid: 1'b0,
    rspData:  '0,
    illegal:  1'b0
  };

  ppih_host_t          s;
  ppih_host_t          next_s;
  logic [`PPIH_DW-1:0] busSync;
  logic                cntDone;

  // Bus is asynchronous to our clock, so read data is synchronised
  ppih_sync #(.W(`PPIH_DW)) u_sync (
    .clk  (clk),
    .rst  (rst),
    .din  (hostDataIn),
    .dout (busSync)
  );

  assign cntDone  = (s.cnt == '0);
  assign cmdReady = (s.state == PPIH_IDLE) && !devResetReq;

  always_comb begin
    next_s          = s;
    next_s.rspValid = 1'b0;
    next_s.illegal  = 1'b0;
    unique case (s.state)
      PPIH_RST: begin
        // Device clears its control word and floats all ports
        if (cntDone) begin
          next_s.resetOut = 1'b0;
          next_s.state    = PPIH_IDLE;
        end else begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
      PPIH_IDLE: begin
        if (devResetReq) begin
          next_s.resetOut = 1'b1;
          next_s.cnt      = `PPIH_CNT_W'(`PPIH_RESET_CYC - 1);
          next_s.state    = PPIH_RST;
        end else if (cmdValid) begin
          if (!cmdWrite && cmdSel == `PPIH_SEL_CTRL) begin
            // Refused without a bus cycle: control is write-only
            next_s.illegal = 1'b1;
          end else begin
            next_s.sel     = cmdSel;
            next_s.write   = cmdWrite;
            next_s.dataOut = cmdData;
            next_s.oe      = cmdWrite;
            next_s.csN     = 1'b0;
            next_s.cnt     = `PPIH_CNT_W'(`PPIH_SETUP_CYC - 1);
            next_s.state   = PPIH_SETUP;
          end
        end
      end
      PPIH_SETUP: begin
        if (cntDone) begin
          next_s.rdN   = s.write;
          next_s.wrN   = !s.write;
          next_s.cnt   = `PPIH_CNT_W'(`PPIH_STROBE_CYC - 1);
          next_s.state = PPIH_STROBE;
        end else begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
      PPIH_STROBE: begin
        if (cntDone) begin
          if (!s.write) begin
            // Sampled at the strobe's end, well after the data delay
            next_s.rspData  = busSync;
            next_s.rspValid = 1'b1;
          end
          next_s.rdN   = 1'b1;
          next_s.wrN   = 1'b1;
          next_s.cnt   = `PPIH_CNT_W'(`PPIH_HOLD_CYC - 1);
          next_s.state = PPIH_HOLD;
        end else begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
      PPIH_HOLD: begin
        // Address and write data held past the strobe's rising edge
        if (cntDone) begin
          next_s.csN   = 1'b1;
          next_s.oe    = 1'b0;
          next_s.cnt   = `PPIH_CNT_W'(`PPIH_RECOV_CYC - 1);
          next_s.state = PPIH_RECOV;
        end else begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
      PPIH_RECOV: begin
        if (cntDone) begin
          next_s.state = PPIH_IDLE;
        end else begin
          next_s.cnt = s.cnt - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= RESET_VAL;
    end else begin
      s <= next_s;
    end
  end

  assign rspValid       = s.rspValid;
  assign rspData        = s.rspData;
  assign cmdIllegal     = s.illegal;
  assign busy           = (s.state != PPIH_IDLE);
  assign deviceReset    = s.resetOut;
  assign deviceSelect_n = s.csN;
  assign readStrobe_n   = s.rdN;
  assign writeStrobe_n  = s.wrN;
  assign portSelectLo   = s.sel[0];
  assign portSelectHi   = s.sel[1];
  assign hostDataOut    = s.dataOut;
  assign hostDataOe     = s.oe;

  localparam int SW = `PPIH_STROBE_CYC;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_strobe_needs_cs: assert property (
    (!readStrobe_n || !writeStrobe_n) |-> !deviceSelect_n)
    else $error("strobe low without chip select");
  chk_one_strobe: assert property (
    !readStrobe_n |-> writeStrobe_n && !hostDataOe)
    else $error("both strobes low or bus driven during read");
  chk_wr_drives: assert property (
    !writeStrobe_n |-> hostDataOe && $stable(hostDataOut))
    else $error("write strobe without stable driven data");
  chk_addr_stable: assert property (
    (!deviceSelect_n && !$past(deviceSelect_n))
      |-> $stable({portSelectHi, portSelectLo}))
    else $error("select lines changed during access");
  chk_oe_in_cycle: assert property (
    hostDataOe |-> !deviceSelect_n && readStrobe_n)
    else $error("data driven outside a write cycle");
  chk_no_ctrl_read: assert property (
    !readStrobe_n |-> {portSelectHi, portSelectLo} != `PPIH_SEL_CTRL)
    else $error("read of control word location");
  chk_illegal_refused: assert property (
    (cmdValid && cmdReady && !cmdWrite && cmdSel == `PPIH_SEL_CTRL)
      |=> cmdIllegal && deviceSelect_n && !busy)
    else $error("control read not refused");
  chk_strobe_width: assert property (
    $fell(writeStrobe_n) |-> ##SW $rose(writeStrobe_n))
    else $error("write strobe width wrong");
  chk_read_width: assert property (
    $fell(readStrobe_n) |-> ##SW $rose(readStrobe_n) ##0 rspValid)
    else $error("read strobe width or response wrong");
  chk_recovery: assert property (
    $rose(deviceSelect_n) |-> deviceSelect_n [*8])
    else $error("select reasserted too soon");
  chk_reset_req: assert property (
    (devResetReq && !busy) |=> deviceReset && deviceSelect_n)
    else $error("device reset not issued");

  cov_write: cover property ($rose(writeStrobe_n) && portSelectHi);
  cov_read: cover property (rspValid);
  cov_illegal: cover property (cmdIllegal);
  cov_reset: cover property ($fell(deviceReset));
endmodule

// *** dv/ppih_dev_model.sv ***
`timescale 1ns/1ps
// Behavioural device: clockless, samples on the write strobe rising edge
module ppih_dev_model (
  input  wire logic       deviceReset,
  input  wire logic       deviceSelect_n,
  input  wire logic       readStrobe_n,
  input  wire logic       writeStrobe_n,
  input  wire logic       portSelectLo,
  input  wire logic       portSelectHi,
  input  wire logic [7:0] busIn,
  output logic      [7:0] devOut,
  output logic            devOe,
  output logic      [7:0] ctrlWord
);
  logic [7:0] portLatch [3];
  logic [1:0] sel;

  assign sel = {portSelectHi, portSelectLo};
  // Control slot never answers a read, so the host sees a floating bus
  assign devOe = !deviceSelect_n && !readStrobe_n
                 && sel != 2'h3;
  assign devOut = (sel == 2'h3) ? 8'h00 : portLatch[sel];

  // Groups one and two both take orders from this one decoder
  always @(posedge writeStrobe_n or posedge deviceReset) begin
    if (deviceReset) begin
      ctrlWord <= 8'h00;
      for (int i = 0; i < 3; i++) portLatch[i] <= 8'h00;
    end else if (!deviceSelect_n) begin
      case (sel)
        2'h3: begin
          if (busIn[7]) begin
            ctrlWord <= busIn;
            for (int i = 0; i < 3; i++) portLatch[i] <= 8'h00;
          end else begin
            portLatch[2][busIn[3:1]] <= busIn[0];
          end
        end
        default: portLatch[sel] <= busIn;
      endcase
    end
  end
endmodule

// *** dv/ppi_host_bus_interface_tb_top.sv ***
`timescale 1ns/1ps
module ppi_host_bus_interface_tb_top;
  logic       clk, rst, cmdValid, cmdReady, cmdWrite, devResetReq;
  logic [1:0] cmdSel;
  logic [7:0] cmdData, rspData, hostDataOut, devOut, ctrlWord;
  logic [7:0] busLevel, rd;
  logic [7:0] lastBus = 8'h00;
  logic       rspValid, cmdIllegal, busy, deviceReset, deviceSelect_n;
  logic       readStrobe_n, writeStrobe_n, portSelectLo, portSelectHi;
  logic       hostDataOe, devOe;
  int         errors, cmp_count, cycles;

  // Undriven bus shows the inverse of its last driven level, never a copy
  assign busLevel = hostDataOe ? hostDataOut : devOe ? devOut : ~lastBus;

  ppih_host uut (.clk(clk), .rst(rst), .cmdValid(cmdValid),
    .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdSel(cmdSel),
    .cmdData(cmdData), .devResetReq(devResetReq), .rspValid(rspValid),
    .rspData(rspData), .cmdIllegal(cmdIllegal), .busy(busy),
    .deviceReset(deviceReset), .deviceSelect_n(deviceSelect_n),
    .readStrobe_n(readStrobe_n), .writeStrobe_n(writeStrobe_n),
    .portSelectLo(portSelectLo), .portSelectHi(portSelectHi),
    .hostDataIn(busLevel), .hostDataOut(hostDataOut),
    .hostDataOe(hostDataOe));

  ppih_dev_model dev (.deviceReset(deviceReset),
    .deviceSelect_n(deviceSelect_n), .readStrobe_n(readStrobe_n),
    .writeStrobe_n(writeStrobe_n), .portSelectLo(portSelectLo),
    .portSelectHi(portSelectHi), .busIn(busLevel), .devOut(devOut),
    .devOe(devOe), .ctrlWord(ctrlWord));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  always @(posedge clk) begin
    if (hostDataOe || devOe) lastBus <= busLevel;
    cycles++;
    if (cycles == 20000) begin
      errors++;
      give_verdict();
    end
  end

  task automatic check(input logic [7:0] got, exp, input string msg);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask

  task automatic give_verdict();
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // One user command; a read of any slot but control waits for the single-cycle response pulse
  task automatic send(input logic wr, input logic [1:0] sel,
                      input logic [7:0] d);
    int n;
    n = 0;
    // An edge first, so back-to-back calls never re-drive in one step
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdSel <= sel;
    cmdData <= d;
    do @(posedge clk); while (cmdReady !== 1'b1 && n++ < 1000);
    check({7'h00, cmdReady}, 8'h01, "command not taken");
    cmdValid <= 1'b0;
    n = 0;
    if (wr) begin
      do @(posedge clk); while (busy !== 1'b0 && n++ < 500);
      check({7'h00, busy}, 8'h00, "write not finished");
    end else if (sel != 2'h3) begin
      do @(posedge clk); while (rspValid !== 1'b1 && n++ < 500);
      check({7'h00, rspValid}, 8'h01, "no read response");
      rd = rspData;
    end
  endtask

  task automatic t_reset();
    int n;
    n = 0;
    repeat (100) @(posedge clk);
    check({7'h00, deviceReset}, 8'h01, "reset pulse too short");
    while (cmdReady !== 1'b1 && n++ < 300) @(posedge clk);
    check({7'h00, deviceReset}, 8'h00, "reset not released");
    check(ctrlWord, 8'h00, "control not cleared");
  endtask

  task automatic t_ports();
    for (int s = 0; s < 3; s++) send(1'b1, s[1:0], 8'hA5 ^ 8'(s * 17));
    for (int s = 0; s < 3; s++) begin
      send(1'b0, s[1:0], 8'h00);
      check(rd, 8'hA5 ^ 8'(s * 17), "port readback");
    end
  endtask

  task automatic t_ctrl();
    logic sawIll, sawCs;
    sawIll = 1'b0;
    sawCs = 1'b0;
    send(1'b1, 2'h2, 8'h00);
    send(1'b1, 2'h3, 8'h0B); // set third port bit 5
    send(1'b0, 2'h2, 8'h00);
    check(rd, 8'h20, "bit set");
    send(1'b1, 2'h3, 8'h9B);
    check(ctrlWord, 8'h9B, "control word");
    send(1'b0, 2'h3, 8'h00);
    repeat (20) begin
      @(posedge clk);
      sawIll |= (cmdIllegal === 1'b1);
      sawCs |= (deviceSelect_n !== 1'b1);
    end
    check({6'h00, sawIll, sawCs}, 8'h02, "control read");
    send(1'b0, 2'h2, 8'h00);
    check(rd, 8'h00, "mode write clears");
  endtask

  task automatic t_devreset();
    int n;
    n = 0;
    send(1'b1, 2'h0, 8'h3C);
    while (cmdReady !== 1'b1 && n++ < 1000) @(posedge clk);
    devResetReq <= 1'b1;
    @(posedge clk);
    devResetReq <= 1'b0;
    repeat (3) @(posedge clk);
    check({7'h00, deviceReset}, 8'h01, "reset request");
    check(ctrlWord, 8'h00, "control after reset");
    send(1'b0, 2'h0, 8'h00);
    check(rd, 8'h00, "port after reset");
  endtask

  initial begin
    rst = 1'b1;
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdSel = 2'h0;
    cmdData = 8'h00;
    devResetReq = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_ports();
    t_ctrl();
    t_devreset();
    give_verdict();
  end
endmodule
